// [rtl/sohctl_pkg.sv]
package sohctl_pkg;

    localparam logic [8:0] SOHCTL_TERM_OH_ADDR   = 9'h0F9;
    localparam logic [8:0] SOHCTL_LINE_MODE_ADDR = 9'h0FA;
    localparam logic [8:0] SOHCTL_TX_CHAN_ADDR   = 9'h1F8;
    localparam logic [8:0] SOHCTL_TX_OH_ADDR     = 9'h1F9;
    localparam logic [8:0] SOHCTL_CLK_RTM_ADDR   = 9'h1FA;
    localparam logic [8:0] SOHCTL_STATUS_ADDR    = 9'h0FE;

    localparam logic [7:0] SOHCTL_REG_RESET      = 8'h00;
    localparam logic [7:0] SOHCTL_CLK_RTM_WMASK  = 8'hEB;

    localparam logic [7:0] SOHCTL_AIS_BYTE       = 8'hFF;
    localparam logic [7:0] SOHCTL_ZERO_BYTE      = 8'h00;

    // Line clock edges per SONET frame (6480 bits)
    localparam int         SOHCTL_FRAME_BITS     = 6480;
    localparam int         SOHCTL_FORCE_FRAMES   = 2;
    localparam logic [12:0] SOHCTL_FRAME_LAST    = 13'(SOHCTL_FRAME_BITS - 1);

    // Bit positions
    localparam int SOHCTL_B_F1  = 7;
    localparam int SOHCTL_B_C1  = 6;
    localparam int SOHCTL_B_Z1  = 5;
    localparam int SOHCTL_B_Z2  = 4;
    localparam int SOHCTL_B_AIS = 3;
    localparam int SOHCTL_B_TE  = 2;
    localparam int SOHCTL_B_FRM = 1;
    localparam int SOHCTL_B_PAR = 0;

    typedef enum logic [3:0] {
        SOHCTL_OH_A1, SOHCTL_OH_A2, SOHCTL_OH_C1, SOHCTL_OH_B1,
        SOHCTL_OH_E1, SOHCTL_OH_F1, SOHCTL_OH_DCC, SOHCTL_OH_H1,
        SOHCTL_OH_H2, SOHCTL_OH_H3, SOHCTL_OH_B2, SOHCTL_OH_APS,
        SOHCTL_OH_Z1, SOHCTL_OH_Z2, SOHCTL_OH_E2, SOHCTL_OH_SPE
    } sohctl_byte_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } sohctl_bus_t;

    typedef struct packed {
        logic rx_los;
        logic rx_lof;
        logic rx_line_ais;
        logic transport_evt;
        logic path_evt;
    } sohctl_alarm_t;

    typedef struct packed {
        logic [7:0]  term_oh;
        logic [7:0]  line_mode;
        logic [7:0]  tx_chan;
        logic [7:0]  tx_oh;
        logic [7:0]  clk_rtm;
        logic [7:0]  rdata;
        logic [2:0]  lclk_sync;
        logic [12:0] bit_cnt;
        logic [1:0]  frame_cnt;
        logic        force_seen;
        logic        force_long;
        logic [1:0]  alarm_prev;
        logic        irq;
        logic [7:0]  term_byte;
        logic [7:0]  line_byte;
    } sohctl_state_t;

endpackage : sohctl_pkg

// [rtl/sohctl_top.sv]
module sohctl_top
    import sohctl_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire sohctl_bus_t   bus,
    output logic [7:0]         rdata,
    input  wire logic          tx_line_clk_in,
    input  wire sohctl_alarm_t alarm_in,
    input  wire sohctl_byte_t  term_byte_sel,
    input  wire logic [7:0]    rx_line_byte,
    input  wire logic [7:0]    ram_byte,
    input  wire logic [7:0]    regen_byte,
    input  wire sohctl_byte_t  line_byte_sel,
    input  wire logic [7:0]    tx_term_byte,
    input  wire logic [7:0]    serial_chan_byte,
    output logic [7:0]         term_out_byte,
    output logic [7:0]         line_out_byte,
    output logic               irq_out,
    output logic               line_scramble_mode,
    output logic               terminal_bus_wide_select,
    output logic               serial_rx_out_en,
    output logic               line_remote_fail_ins,
    output logic               orderwire_align_select,
    output logic               orderwire_protect_to_ram,
    output logic               rx_to_tx_loopback,
    output logic               line_auto_alarm_insert,
    output logic               spe_only_active,
    output logic               retime_active,
    output logic               tx_line_clk_source,
    output logic               term_clk_from_tx_line,
    output logic               tx_auto_justify_en,
    output logic               force_pointer_up,
    output logic               force_pointer_down
);

    sohctl_state_t s_q;
    sohctl_state_t s_d;

    logic lclk_rise;
    logic spe_only;
    logic retime_en;
    logic [1:0] alarm_edge;
    logic [1:0] alarm_now;

    // Pick RAM, regenerated or pass-through value for one byte
    function automatic logic [7:0] pick(input logic use_ram, input logic [7:0] ram,
                                        input logic [7:0] pass);
        pick = use_ram ? ram : pass;
    endfunction : pick

    function automatic logic keeps_framing(input sohctl_byte_t b);
        keeps_framing = (b == SOHCTL_OH_A1) || (b == SOHCTL_OH_A2) ||
                        (b == SOHCTL_OH_E1) || (b == SOHCTL_OH_H1) ||
                        (b == SOHCTL_OH_H2);
    endfunction : keeps_framing

    assign retime_en  = !s_q.tx_oh[1];
    assign spe_only   = s_q.clk_rtm[7] && retime_en;
    assign lclk_rise  = s_q.lclk_sync[1] && !s_q.lclk_sync[2];
    assign alarm_now  = {alarm_in.transport_evt, alarm_in.path_evt};
    // Edge mode: rising only, or both edges when selected
    assign alarm_edge = s_q.line_mode[0] ? (alarm_now ^ s_q.alarm_prev)
                                         : (alarm_now & ~s_q.alarm_prev);

    always_comb begin
        logic [7:0] tb;
        logic [7:0] lb;
        logic       irq_src;
        s_d = s_q;
        tb = rx_line_byte;
        lb = tx_term_byte;
        irq_src = 1'b0;
        s_d.rdata = SOHCTL_ZERO_BYTE;

        if (bus.wr) begin
            unique case (bus.addr)
                SOHCTL_TERM_OH_ADDR:   s_d.term_oh = bus.wdata;
                SOHCTL_LINE_MODE_ADDR: s_d.line_mode = bus.wdata;
                SOHCTL_TX_CHAN_ADDR:   s_d.tx_chan = bus.wdata;
                SOHCTL_TX_OH_ADDR:     s_d.tx_oh = bus.wdata;
                // Undefined bits stay low whatever software writes
                SOHCTL_CLK_RTM_ADDR:   s_d.clk_rtm = bus.wdata & SOHCTL_CLK_RTM_WMASK;
                default: ;
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                SOHCTL_TERM_OH_ADDR:   s_d.rdata = s_q.term_oh;
                SOHCTL_LINE_MODE_ADDR: s_d.rdata = s_q.line_mode;
                SOHCTL_TX_CHAN_ADDR:   s_d.rdata = s_q.tx_chan;
                SOHCTL_TX_OH_ADDR:     s_d.rdata = s_q.tx_oh;
                SOHCTL_CLK_RTM_ADDR:   s_d.rdata = s_q.clk_rtm;
                SOHCTL_STATUS_ADDR:    s_d.rdata = {3'h0, s_q.force_seen, s_q.frame_cnt,
                                                    spe_only, s_q.irq};
                default:               s_d.rdata = SOHCTL_ZERO_BYTE;
            endcase
        end

        // Link clock sampled twice before the edge detector sees it
        s_d.lclk_sync = {s_q.lclk_sync[1:0], tx_line_clk_in};

        // Forced justification: count frames of line clock while held
        if (!(s_q.clk_rtm[1] || s_q.clk_rtm[0])) begin
            s_d.bit_cnt = '0;
            s_d.frame_cnt = '0;
            s_d.force_seen = 1'b0;
        end else if (lclk_rise) begin
            s_d.force_seen = 1'b1;
            if (s_q.bit_cnt == SOHCTL_FRAME_LAST) begin
                s_d.bit_cnt = '0;
                if (s_q.frame_cnt != 2'(SOHCTL_FORCE_FRAMES))
                    s_d.frame_cnt = s_q.frame_cnt + 2'h1;
            end else begin
                s_d.bit_cnt = s_q.bit_cnt + 13'h1;
            end
        end
        // Held past the allowed frames: software broke the clear rule
        s_d.force_long = (s_q.frame_cnt == 2'(SOHCTL_FORCE_FRAMES));

        // Interrupts gated by layer enables and the hardware gate
        s_d.alarm_prev = alarm_now;
        // Each layer sees its own edge, so a falling edge counts in both-edge mode
        if ((s_q.line_mode[2] && alarm_edge[1]) ||
            (s_q.line_mode[1] && alarm_edge[0]))
            irq_src = 1'b1;
        if (irq_src)
            s_d.irq = 1'b1;
        else if (bus.rd && bus.addr == SOHCTL_STATUS_ADDR)
            s_d.irq = 1'b0;

        // Terminal-side outgoing byte
        unique case (term_byte_sel)
            SOHCTL_OH_F1: tb = pick(s_q.term_oh[SOHCTL_B_F1], ram_byte, rx_line_byte);
            SOHCTL_OH_C1: tb = pick(s_q.term_oh[SOHCTL_B_C1], ram_byte, rx_line_byte);
            SOHCTL_OH_Z1: tb = pick(s_q.term_oh[SOHCTL_B_Z1], ram_byte, rx_line_byte);
            SOHCTL_OH_Z2: tb = pick(s_q.term_oh[SOHCTL_B_Z2], ram_byte, rx_line_byte);
            SOHCTL_OH_A1, SOHCTL_OH_A2:
                tb = pick(s_q.term_oh[SOHCTL_B_FRM], regen_byte, rx_line_byte);
            SOHCTL_OH_B1: tb = pick(s_q.term_oh[SOHCTL_B_PAR], regen_byte, rx_line_byte);
            SOHCTL_OH_B2: tb = pick(s_q.tx_oh[SOHCTL_B_PAR] && !retime_en,
                                    regen_byte, rx_line_byte);
            default:      tb = rx_line_byte;
        endcase
        if (retime_en && term_byte_sel != SOHCTL_OH_SPE && !keeps_framing(term_byte_sel))
            tb = SOHCTL_ZERO_BYTE;
        if (retime_en && s_q.term_oh[SOHCTL_B_AIS] &&
            (s_q.term_oh[SOHCTL_B_TE] || s_q.tx_oh[SOHCTL_B_TE])) begin
            if (term_byte_sel == SOHCTL_OH_SPE)
                tb = SOHCTL_AIS_BYTE;
            else if (!keeps_framing(term_byte_sel))
                tb = SOHCTL_ZERO_BYTE;
        end
        s_d.term_byte = tb;

        // Line-side outgoing byte; SPE-only bars terminal source for F1, C1, Z1, Z2, DCC, E1, E2 and APS
        unique case (line_byte_sel)
            SOHCTL_OH_F1: lb = pick(s_q.tx_oh[SOHCTL_B_F1] || spe_only, ram_byte, tx_term_byte);
            SOHCTL_OH_C1: lb = pick(s_q.tx_oh[SOHCTL_B_C1] || spe_only, ram_byte, tx_term_byte);
            SOHCTL_OH_Z1: lb = pick(s_q.tx_oh[SOHCTL_B_Z1] || spe_only, ram_byte, tx_term_byte);
            SOHCTL_OH_Z2: lb = pick(s_q.tx_oh[SOHCTL_B_Z2] || spe_only, ram_byte, tx_term_byte);
            SOHCTL_OH_DCC: lb = pick(s_q.tx_chan[7] || s_q.tx_chan[6] || spe_only,
                                     serial_chan_byte, tx_term_byte);
            SOHCTL_OH_E1: lb = pick(s_q.tx_chan[5] || spe_only, serial_chan_byte, tx_term_byte);
            SOHCTL_OH_E2: lb = pick(s_q.tx_chan[4] || spe_only, serial_chan_byte, tx_term_byte);
            SOHCTL_OH_APS: lb = pick(s_q.tx_chan[2] || spe_only, ram_byte, tx_term_byte);
            SOHCTL_OH_SPE: lb = pick(s_q.tx_chan[3], ram_byte, tx_term_byte);
            SOHCTL_OH_B1: lb = pick(s_q.line_mode[7], regen_byte, tx_term_byte);
            default:      lb = tx_term_byte;
        endcase
        if (s_q.tx_oh[SOHCTL_B_AIS] && (alarm_in.rx_los || alarm_in.rx_lof ||
            alarm_in.rx_line_ais) && !keeps_framing(line_byte_sel))
            lb = SOHCTL_AIS_BYTE;
        s_d.line_byte = lb;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata                    = s_q.rdata;
    assign term_out_byte            = s_q.term_byte;
    assign line_out_byte            = s_q.line_byte;
    assign irq_out                  = s_q.irq && s_q.line_mode[5];
    assign line_scramble_mode       = s_q.line_mode[7];
    assign terminal_bus_wide_select = s_q.line_mode[6];
    assign serial_rx_out_en         = s_q.line_mode[6] || !spe_only;
    assign line_remote_fail_ins     = s_q.line_mode[4] && (alarm_in.rx_los ||
                                      alarm_in.rx_lof || alarm_in.rx_line_ais);
    assign orderwire_align_select   = s_q.line_mode[3];
    assign orderwire_protect_to_ram = s_q.tx_chan[1] && !spe_only;
    assign rx_to_tx_loopback        = s_q.tx_chan[0];
    assign line_auto_alarm_insert   = s_q.tx_oh[SOHCTL_B_AIS];
    assign spe_only_active          = spe_only;
    assign retime_active            = retime_en;
    assign tx_line_clk_source       = s_q.clk_rtm[6];
    assign term_clk_from_tx_line    = s_q.clk_rtm[5] && retime_en;
    assign tx_auto_justify_en       = s_q.clk_rtm[3];
    // Forcing stops by itself once two frames pass, limiting repeats
    assign force_pointer_up         = s_q.clk_rtm[1] && !s_q.force_long;
    assign force_pointer_down       = s_q.clk_rtm[0] && !s_q.force_long;

    property p_read_data;
        @(posedge clk) disable iff (!rst_b)
        bus.rd && bus.addr == SOHCTL_TERM_OH_ADDR && !bus.wr |=> rdata == $past(s_q.term_oh);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    property p_reserved_low;
        @(posedge clk) disable iff (!rst_b)
        bus.wr && bus.addr == SOHCTL_CLK_RTM_ADDR |=> s_q.clk_rtm[4] == 1'b0 && !s_q.clk_rtm[2];
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("undefined bit set");

    property p_irq_gate;
        @(posedge clk) disable iff (!rst_b)
        !s_q.line_mode[5] |-> !irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

    property p_ferf;
        @(posedge clk) disable iff (!rst_b)
        s_q.line_mode[4] && alarm_in.rx_lof |-> line_remote_fail_ins;
    endproperty
    a_ferf: assert property (p_ferf) else $error("ferf missing");

    property p_spe_needs_retime;
        @(posedge clk) disable iff (!rst_b)
        spe_only_active |-> !s_q.tx_oh[1];
    endproperty
    a_spe_needs_retime: assert property (p_spe_needs_retime) else $error("spe bad");

    property p_retime_zero;
        @(posedge clk) disable iff (!rst_b)
        retime_en && term_byte_sel == SOHCTL_OH_C1 |=> term_out_byte == SOHCTL_ZERO_BYTE;
    endproperty
    a_retime_zero: assert property (p_retime_zero) else $error("toh not zero");

    property p_loop;
        @(posedge clk) disable iff (!rst_b)
        bus.wr && bus.addr == SOHCTL_TX_CHAN_ADDR ##1 1'b1 |-> rx_to_tx_loopback == $past(bus.wdata[0]);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback wrong");

    property p_force_stop;
        @(posedge clk) disable iff (!rst_b)
        s_q.frame_cnt == 2'(SOHCTL_FORCE_FRAMES) |=> !force_pointer_up && !force_pointer_down;
    endproperty
    a_force_stop: assert property (p_force_stop) else $error("force not limited");

    property p_wr_term_oh;
        @(posedge clk) disable iff (!rst_b)
        bus.wr && bus.addr == SOHCTL_TERM_OH_ADDR |=> s_q.term_oh == $past(bus.wdata);
    endproperty
    a_wr_term_oh: assert property (p_wr_term_oh) else $error("write lost");

    property p_term_ram;
        @(posedge clk) disable iff (!rst_b)
        !retime_en && s_q.term_oh[SOHCTL_B_F1] && term_byte_sel == SOHCTL_OH_F1
            |=> term_out_byte == $past(ram_byte);
    endproperty
    a_term_ram: assert property (p_term_ram) else $error("F1 not from RAM");

    property p_term_pass;
        @(posedge clk) disable iff (!rst_b)
        !retime_en && !s_q.term_oh[SOHCTL_B_C1] && term_byte_sel == SOHCTL_OH_C1
            |=> term_out_byte == $past(rx_line_byte);
    endproperty
    a_term_pass: assert property (p_term_pass) else $error("C1 not passed");

    property p_retime_keep;
        @(posedge clk) disable iff (!rst_b)
        retime_en && term_byte_sel == SOHCTL_OH_E1 |=> term_out_byte == $past(rx_line_byte);
    endproperty
    a_retime_keep: assert property (p_retime_keep) else $error("E1 not kept");

    property p_ais_spe;
        @(posedge clk) disable iff (!rst_b)
        retime_en && s_q.term_oh[SOHCTL_B_AIS] && s_q.term_oh[SOHCTL_B_TE] &&
        term_byte_sel == SOHCTL_OH_SPE |=> term_out_byte == SOHCTL_AIS_BYTE;
    endproperty
    a_ais_spe: assert property (p_ais_spe) else $error("payload not ones");

    property p_section_term;
        @(posedge clk) disable iff (!rst_b)
        retime_en && !s_q.term_oh[SOHCTL_B_TE] && !s_q.tx_oh[SOHCTL_B_TE] &&
        term_byte_sel == SOHCTL_OH_SPE |=> term_out_byte == $past(rx_line_byte);
    endproperty
    a_section_term: assert property (p_section_term) else $error("AIS without LINE_TERM_EQUIP_EN/PATH_TERM_EQUIP_EN");

    property p_b2_retime;
        @(posedge clk) disable iff (!rst_b)
        retime_en && term_byte_sel == SOHCTL_OH_B2 |=> term_out_byte == SOHCTL_ZERO_BYTE;
    endproperty
    a_b2_retime: assert property (p_b2_retime) else $error("B2 not zero");

    property p_b1_regen;
        @(posedge clk) disable iff (!rst_b)
        !retime_en && s_q.term_oh[SOHCTL_B_PAR] && term_byte_sel == SOHCTL_OH_B1
            |=> term_out_byte == $past(regen_byte);
    endproperty
    a_b1_regen: assert property (p_b1_regen) else $error("B1 not recalculated");

    property p_line_b1;
        @(posedge clk) disable iff (!rst_b)
        s_q.line_mode[7] && !s_q.tx_oh[SOHCTL_B_AIS] && line_byte_sel == SOHCTL_OH_B1
            |=> line_out_byte == $past(regen_byte);
    endproperty
    a_line_b1: assert property (p_line_b1) else $error("line B1 wrong");

    property p_wide;
        @(posedge clk) disable iff (!rst_b)
        bus.wr && bus.addr == SOHCTL_LINE_MODE_ADDR
            |=> terminal_bus_wide_select == $past(bus.wdata[6]);
    endproperty
    a_wide: assert property (p_wide) else $error("bus width wrong");

    property p_irq_rise;
        @(posedge clk) disable iff (!rst_b)
        s_q.line_mode[2] && alarm_in.transport_evt && !s_q.alarm_prev[1] |=> s_q.irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("transport irq lost");

    property p_irq_path_fall;
        @(posedge clk) disable iff (!rst_b)
        s_q.line_mode[1] && s_q.line_mode[0] && !alarm_in.path_evt && s_q.alarm_prev[0]
            |=> s_q.irq;
    endproperty
    a_irq_path_fall: assert property (p_irq_path_fall) else $error("path fall lost");

    property p_line_chan;
        @(posedge clk) disable iff (!rst_b)
        s_q.tx_chan[5] && line_byte_sel == SOHCTL_OH_E1
            |=> line_out_byte == $past(serial_chan_byte);
    endproperty
    a_line_chan: assert property (p_line_chan) else $error("E1 not serial");

    property p_aps_ram;
        @(posedge clk) disable iff (!rst_b)
        s_q.tx_chan[2] && !s_q.tx_oh[SOHCTL_B_AIS] && line_byte_sel == SOHCTL_OH_APS
            |=> line_out_byte == $past(ram_byte);
    endproperty
    a_aps_ram: assert property (p_aps_ram) else $error("APS not from RAM");

    property p_spe_ram;
        @(posedge clk) disable iff (!rst_b)
        spe_only && !s_q.tx_oh[SOHCTL_B_AIS] && line_byte_sel == SOHCTL_OH_C1
            |=> line_out_byte == $past(ram_byte);
    endproperty
    a_spe_ram: assert property (p_spe_ram) else $error("terminal source in SPE");

    property p_line_f1;
        @(posedge clk) disable iff (!rst_b)
        s_q.tx_oh[SOHCTL_B_F1] && !s_q.tx_oh[SOHCTL_B_AIS] && line_byte_sel == SOHCTL_OH_F1
            |=> line_out_byte == $past(ram_byte);
    endproperty
    a_line_f1: assert property (p_line_f1) else $error("line F1 wrong");

    property p_line_ais;
        @(posedge clk) disable iff (!rst_b)
        s_q.tx_oh[SOHCTL_B_AIS] && alarm_in.rx_lof && line_byte_sel == SOHCTL_OH_SPE
            |=> line_out_byte == SOHCTL_AIS_BYTE;
    endproperty
    a_line_ais: assert property (p_line_ais) else $error("line AIS missing");

endmodule : sohctl_top

// [bench/sohctl_line_model.sv]
module sohctl_line_model
    import sohctl_pkg::*;
(
    input  wire logic           run,
    input  wire sohctl_alarm_t  alarm_set,
    output logic                lclk,
    output sohctl_alarm_t       alarm,
    output logic [7:0]          rx_line_byte,
    output logic [7:0]          ram_byte,
    output logic [7:0]          regen_byte,
    output logic [7:0]          tx_term_byte,
    output logic [7:0]          serial_chan_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // Line clock at 48 ns, held low between bursts
    initial lclk = 1'b0;
    always begin
        #24;
        lclk = run ? ~lclk : 1'b0;
    end

    assign alarm = alarm_set;
    // Distinct values so every source is told apart at the outputs
    assign rx_line_byte     = 8'h11;
    assign ram_byte         = 8'h22;
    assign regen_byte       = 8'h33;
    assign tx_term_byte     = 8'h44;
    assign serial_chan_byte = 8'h55;
endmodule : sohctl_line_model

// [bench/sohctl_top_tb.sv]
module sohctl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sohctl_pkg::*;

    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    logic          run = 1'b0;
    sohctl_bus_t   bus = '0;
    sohctl_alarm_t alarm_set = '0;
    sohctl_alarm_t alarm_in;
    sohctl_byte_t  term_byte_sel = SOHCTL_OH_A1;
    sohctl_byte_t  line_byte_sel = SOHCTL_OH_A1;
    logic          tx_line_clk_in;
    logic [7:0]    rdata, term_out_byte, line_out_byte;
    logic [7:0]    rx_line_byte, ram_byte, regen_byte, tx_term_byte, serial_chan_byte;
    logic          irq_out, line_scramble_mode, terminal_bus_wide_select, serial_rx_out_en;
    logic          line_remote_fail_ins, orderwire_align_select, orderwire_protect_to_ram;
    logic          rx_to_tx_loopback, line_auto_alarm_insert, spe_only_active, retime_active;
    logic          tx_line_clk_source, term_clk_from_tx_line, tx_auto_justify_en;
    logic          force_pointer_up, force_pointer_down;
    int            err_total = 0;
    int            tests_run = 0;
    logic [8:0]    addrs [5] = '{9'h0F9, 9'h0FA, 9'h1F8, 9'h1F9, 9'h1FA};
    // Retime stays enabled so the SPE-only and clock selects are legal
    logic [7:0]    wval [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'hEB};

    always #2.5 clk = ~clk;

    sohctl_line_model u_line (.run, .alarm_set, .lclk(tx_line_clk_in), .alarm(alarm_in),
        .rx_line_byte, .ram_byte, .regen_byte, .tx_term_byte, .serial_chan_byte);

    sohctl_top DUT (.clk, .rst_b, .bus, .rdata, .tx_line_clk_in, .alarm_in, .term_byte_sel,
        .rx_line_byte, .ram_byte, .regen_byte, .line_byte_sel, .tx_term_byte,
        .serial_chan_byte, .term_out_byte, .line_out_byte, .irq_out, .line_scramble_mode,
        .terminal_bus_wide_select, .serial_rx_out_en, .line_remote_fail_ins,
        .orderwire_align_select, .orderwire_protect_to_ram, .rx_to_tx_loopback,
        .line_auto_alarm_insert, .spe_only_active, .retime_active, .tx_line_clk_source,
        .term_clk_from_tx_line, .tx_auto_justify_en, .force_pointer_up, .force_pointer_down);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic bchk(input logic line, input sohctl_byte_t s, input logic [7:0] exp);
        @(posedge clk);
        if (line) line_byte_sel <= s;
        else term_byte_sel <= s;
        settle();
        chk(line ? line_out_byte : term_out_byte, exp);
    endtask : bchk

    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end

    initial begin
        sohctl_byte_t four [4];
        four = '{SOHCTL_OH_F1, SOHCTL_OH_C1, SOHCTL_OH_Z1, SOHCTL_OH_Z2};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        chk({6'h00, retime_active, serial_rx_out_en}, 8'h03);
        chk({irq_out, line_scramble_mode, tx_auto_justify_en, force_pointer_up,
             spe_only_active, rx_to_tx_loopback, line_remote_fail_ins, 1'b0}, 8'h00);
        foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
        // Undefined bits of the clock register always written low
        foreach (addrs[i]) wr(addrs[i], wval[i]);
        foreach (addrs[i]) rd_chk(addrs[i], wval[i]);
        rd_chk(9'h100, 8'h00);
        chk({line_scramble_mode, terminal_bus_wide_select, orderwire_align_select,
             rx_to_tx_loopback, orderwire_protect_to_ram, line_auto_alarm_insert,
             retime_active, spe_only_active}, 8'hF7);
        chk({tx_line_clk_source, term_clk_from_tx_line, tx_auto_justify_en,
             force_pointer_up, force_pointer_down, 3'h0}, 8'hF8);
        wr(9'h1FA, 8'h00);
        foreach (four[i]) begin
            @(posedge clk) alarm_set <= (i == 0) ? 5'h10 : (i == 1) ? 5'h08 :
                                        (i == 2) ? 5'h04 : 5'h00;
            settle();
            chk({7'h00, line_remote_fail_ins}, (i == 3) ? 8'h00 : 8'h01);
        end
        @(posedge clk) alarm_set <= 5'h08;
        settle();
        chk({7'h00, line_remote_fail_ins}, 8'h01);
        wr(9'h0FA, 8'hEF);
        settle();
        chk({7'h00, line_remote_fail_ins}, 8'h00);
        bchk(1'b1, SOHCTL_OH_SPE, 8'hFF);
        @(posedge clk) alarm_set <= '0;
        wr(9'h1F9, 8'h02);
        wr(9'h0F9, 8'hF0);
        foreach (four[i]) bchk(1'b0, four[i], 8'h22);
        wr(9'h0F9, 8'h03);
        foreach (four[i]) bchk(1'b0, four[i], 8'h11);
        bchk(1'b0, SOHCTL_OH_A1, 8'h33);
        bchk(1'b1, SOHCTL_OH_B1, 8'h33);
        wr(9'h1F9, 8'hF2);
        foreach (four[i]) bchk(1'b1, four[i], 8'h22);
        wr(9'h1F9, 8'h02);
        foreach (four[i]) bchk(1'b1, four[i], 8'h44);
        wr(9'h1F8, 8'h30);
        bchk(1'b1, SOHCTL_OH_E1, 8'h55);
        wr(9'h1F8, 8'h00);
        bchk(1'b1, SOHCTL_OH_E1, 8'h44);
        wr(9'h1F9, 8'h00);
        wr(9'h0F9, 8'hF0);
        bchk(1'b0, SOHCTL_OH_C1, 8'h00);
        wr(9'h0F9, 8'h0C);
        bchk(1'b0, SOHCTL_OH_SPE, 8'hFF);
        wr(9'h1FA, 8'h80);
        settle();
        chk({6'h00, spe_only_active, retime_active}, 8'h03);
        wr(9'h1FA, 8'h00);
        wr(9'h0FA, 8'h04);
        @(posedge clk) alarm_set <= 5'h02;
        settle();
        chk({7'h00, irq_out}, 8'h00);
        wr(9'h0FA, 8'h24);
        settle();
        chk({7'h00, irq_out}, 8'h01);
        @(posedge clk) alarm_set <= '0;
        rd_chk(SOHCTL_STATUS_ADDR, 8'h01);
        settle();
        chk({7'h00, irq_out}, 8'h00);
        wr(9'h0FA, 8'h23);
        @(posedge clk) alarm_set <= 5'h01;
        settle();
        rd_chk(SOHCTL_STATUS_ADDR, 8'h01);
        @(posedge clk) alarm_set <= '0;
        settle();
        chk({7'h00, irq_out}, 8'h01);
        rd_chk(SOHCTL_STATUS_ADDR, 8'h01);
        run <= 1'b1;
        wr(9'h1FA, 8'h02);
        repeat (2000) @(posedge clk);
        #1;
        chk({7'h00, force_pointer_up}, 8'h01);
        rd_chk(SOHCTL_STATUS_ADDR, 8'h10);
        wr(9'h1FA, 8'h00);
        run <= 1'b0;
        settle();
        chk({6'h00, force_pointer_up, force_pointer_down}, 8'h00);
        final_report();
    end
endmodule : sohctl_top_tb
